//--- logic/pirc_top.sv
// Interrupt controller: flags, enables, levels, trace and global control.
`timescale 1ns/1ps
module pirc_top
  import pirc_pkg::*;
#(
  parameter int N_SRC = SRC_COUNT
) (
  input wire logic mclk_i, // System clock
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic [ADDR_W-1:0] reg_addr_i, // Register word address
  input wire logic [DATA_W-1:0] reg_wdata_i, // Register write data
  input wire logic reg_we_i, // Write strobe
  input wire logic reg_re_i, // Read strobe
  output logic [DATA_W-1:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic [N_SRC-1:0] src_event_i, // Peripheral event pulses
  input wire logic [EXT_COUNT-1:0] ext_irq_i, // External interrupt pins
  input wire logic [TRAP_COUNT-1:0] trap_event_i, // Trap event pulses
  input wire logic disable_instr_active_active_i, // Disable instruction running
  input wire logic irq_ack_i, // CPU takes the offered interrupt
  input wire logic cpu_level_load_i, // CPU restores its level
  input wire logic [LEVEL_W-1:0] cpu_level_i, // Level to restore
  output logic irq_req_o, // Interrupt request to CPU
  output logic [VEC_W-1:0] irq_vector_o, // Latched vector index
  output logic [LEVEL_W-1:0] irq_level_o, // Latched level
  output logic [DATA_W-1:0] vec_addr_o, // Handler fetch address
  output logic [LEVEL_W-1:0] cpu_prio_level_o, // Current CPU level
  output logic nesting_off_o // Nesting disabled
);

  // -----------------------------------------------------------------------
  // Elaboration checks
  // -----------------------------------------------------------------------
  generate
    if (N_SRC != SRC_COUNT) begin : g_bad
      $error("pirc_top: source count must match the register bank");
    end
  endgenerate

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  function automatic logic [DATA_W-1:0] bank_word(
    input logic [SRC_COUNT-1:0] v,
    input int k
  );
    bank_word = v[k*DATA_W +: DATA_W] & IMPL_MASK[k*DATA_W +: DATA_W];
  endfunction

  function automatic logic [DATA_W-1:0] prio_word(
    input logic [SRC_COUNT-1:0][PRIO_W-1:0] p,
    input int k
  );
    logic [DATA_W-1:0] w;
    int v;
    w = '0;
    for (int j = 0; j < FIELDS_PER_REG; j++) begin
      v = k * FIELDS_PER_REG + j;
      if (IMPL_MASK[v]) begin
        w[j*PRIO_STRIDE +: PRIO_W] = p[v];
      end
    end
    prio_word = w;
  endfunction

  function automatic logic prio_reg_ok(input int k);
    prio_reg_ok = (k < PRIO_REGS) && (k != PRIO_GAP_A) && (k != PRIO_GAP_B);
  endfunction

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  pirc_state_s s;
  pirc_state_s next_s;
  pirc_win_s win;
  logic [N_SRC-1:0] pend;
  logic [LEVEL_W-1:0] cpu_level;

  assign cpu_level = {s.cpu_prio_msb, s.ipl_low};
  assign pend = s.flags & s.enables;

  pirc_arbiter #(
    .N_SRC(N_SRC)
  ) u_arb (
    .pend_i(pend),
    .prio_i(s.prio),
    .cpu_level_i(cpu_level),
    .win_o(win)
  );

  // -----------------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------------
  always_comb begin
    logic [EXT_COUNT-1:0] ext_evt;
    logic [SRC_COUNT-1:0] hw_set;
    int rel;
    int v;
    ext_evt = '0;
    hw_set = '0;
    rel = 0;
    v = 0;
    next_s = s;
    next_s.rdata = '0;

    // External pins: edge chosen per pin by its select bit.
    for (int e = 0; e < EXT_COUNT; e++) begin
      if (s.edge_sel[e]) begin
        ext_evt[e] = s.ext_prev[e] & ~ext_irq_i[e];
      end else begin
        ext_evt[e] = ~s.ext_prev[e] & ext_irq_i[e];
      end
    end
    next_s.ext_prev = ext_irq_i;
    hw_set = src_event_i;
    for (int e = 0; e < EXT_COUNT; e++) begin
      hw_set[EXT_VEC[e]] = hw_set[EXT_VEC[e]] | ext_evt[e];
    end

    // Register writes.
    if (reg_we_i) begin
      if (reg_addr_i == OFF_STATUS) begin
        if (!s.nesting_off) begin
          next_s.ipl_low = reg_wdata_i[IPL_HI:IPL_LO];
        end
      end else if (reg_addr_i == OFF_GCTL_A) begin
        next_s.nesting_off = reg_wdata_i[NEST_BIT];
        next_s.trap = reg_wdata_i[TRAP_HI:TRAP_LO];
      end else if (reg_addr_i == OFF_GCTL_B) begin
        next_s.alt_table_select = reg_wdata_i[ALT_BIT];
        next_s.edge_sel = reg_wdata_i[EDGE_HI:EDGE_LO];
      end else if (reg_addr_i >= OFF_FLAG &&
                   reg_addr_i < OFF_FLAG + ADDR_W'(BANKS)) begin
        rel = int'(reg_addr_i - OFF_FLAG);
        for (int b = 0; b < DATA_W; b++) begin
          v = rel * DATA_W + b;
          next_s.flags[v] = reg_wdata_i[b] & IMPL_MASK[v];
        end
      end else if (reg_addr_i >= OFF_ENABLE &&
                   reg_addr_i < OFF_ENABLE + ADDR_W'(BANKS)) begin
        rel = int'(reg_addr_i - OFF_ENABLE);
        for (int b = 0; b < DATA_W; b++) begin
          v = rel * DATA_W + b;
          next_s.enables[v] = reg_wdata_i[b] & IMPL_MASK[v];
        end
      end else if (reg_addr_i >= OFF_PRIO &&
                   reg_addr_i < OFF_PRIO + ADDR_W'(PRIO_REGS)) begin
        rel = int'(reg_addr_i - OFF_PRIO);
        if (prio_reg_ok(rel)) begin
          for (int j = 0; j < FIELDS_PER_REG; j++) begin
            v = rel * FIELDS_PER_REG + j;
            if (IMPL_MASK[v]) begin
              next_s.prio[v] = reg_wdata_i[j*PRIO_STRIDE +: PRIO_W];
            end
          end
        end
      end
    end

    // Hardware sets come after the write so a same-cycle clear loses.
    next_s.flags = next_s.flags | (hw_set & IMPL_MASK);
    next_s.trap = next_s.trap | trap_event_i;

    // Winner is latched into the trace and offered to the CPU.
    next_s.req = win.hit;
    if (win.hit) begin
      next_s.latched_vector_index = win.vec;
      next_s.latched_prio_level = win.lvl;
      if (s.alt_table_select) begin
        next_s.vec_addr = ALT_VECTOR_TABLE_BASE + {win.vec, 1'b0};
      end else begin
        next_s.vec_addr = IVT_BASE + {win.vec, 1'b0};
      end
    end

    // Taking an interrupt raises the CPU level; with nesting off to the top
    // so that nothing else preempts the handler.
    if (irq_ack_i) begin
      if (s.nesting_off) begin
        next_s.ipl_low = PRIO_MAX;
      end else begin
        next_s.ipl_low = s.latched_prio_level[PRIO_W-1:0];
      end
    end
    if (cpu_level_load_i) begin
      next_s.ipl_low = cpu_level_i[PRIO_W-1:0];
      next_s.cpu_prio_msb = cpu_level_i[LEVEL_W-1];
    end

    // Register reads: data stands only in the cycle after the strobe.
    if (reg_re_i) begin
      if (reg_addr_i == OFF_STATUS) begin
        next_s.rdata[IPL_HI:IPL_LO] = s.ipl_low;
      end else if (reg_addr_i == OFF_CORE) begin
        next_s.rdata[CORE_MSB_BIT] = s.cpu_prio_msb;
        next_s.rdata[CORE_RSVD_BIT] = 1'b1;
      end else if (reg_addr_i == OFF_GCTL_A) begin
        next_s.rdata[NEST_BIT] = s.nesting_off;
        next_s.rdata[TRAP_HI:TRAP_LO] = s.trap;
      end else if (reg_addr_i == OFF_GCTL_B) begin
        next_s.rdata[ALT_BIT] = s.alt_table_select;
        next_s.rdata[DISABLE_INSTR_ACTIVE_BIT] = disable_instr_active_active_i;
        next_s.rdata[EDGE_HI:EDGE_LO] = s.edge_sel;
      end else if (reg_addr_i == OFF_TRACE) begin
        next_s.rdata[VEC_W-1:0] = s.latched_vector_index;
        next_s.rdata[TRACE_LVL_HI:TRACE_LVL_LO] = s.latched_prio_level;
      end else if (reg_addr_i >= OFF_FLAG &&
                   reg_addr_i < OFF_FLAG + ADDR_W'(BANKS)) begin
        next_s.rdata = bank_word(s.flags, int'(reg_addr_i - OFF_FLAG));
      end else if (reg_addr_i >= OFF_ENABLE &&
                   reg_addr_i < OFF_ENABLE + ADDR_W'(BANKS)) begin
        next_s.rdata = bank_word(s.enables, int'(reg_addr_i - OFF_ENABLE));
      end else if (reg_addr_i >= OFF_PRIO &&
                   reg_addr_i < OFF_PRIO + ADDR_W'(PRIO_REGS)) begin
        rel = int'(reg_addr_i - OFF_PRIO);
        if (prio_reg_ok(rel)) begin
          next_s.rdata = prio_word(s.prio, rel);
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign reg_rdata_o = s.rdata;
  assign irq_req_o = s.req;
  assign irq_vector_o = s.latched_vector_index;
  assign irq_level_o = s.latched_prio_level;
  assign vec_addr_o = s.vec_addr;
  assign cpu_prio_level_o = {s.cpu_prio_msb, s.ipl_low};
  assign nesting_off_o = s.nesting_off;

endmodule

//--- logic/pirc_pkg.sv
// Package: register map, field layout and state of the interrupt controller.
package pirc_pkg;

  // ---------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int BANKS = 6;
  localparam int SRC_COUNT = 96;
  localparam int PRIO_W = 3;
  localparam int LEVEL_W = 4;
  localparam int VEC_W = 7;
  localparam int FIELDS_PER_REG = 4;
  localparam int PRIO_REGS = 24;
  localparam int PRIO_GAP_A = 14;
  localparam int PRIO_GAP_B = 17;
  localparam int EXT_COUNT = 5;
  localparam int TRAP_COUNT = 4;

  // ---------------------------------------------------------------------
  // Register offsets (word addresses on the register port)
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CORE = 8'h01;
  localparam logic [ADDR_W-1:0] OFF_GCTL_A = 8'h02;
  localparam logic [ADDR_W-1:0] OFF_GCTL_B = 8'h03;
  localparam logic [ADDR_W-1:0] OFF_TRACE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FLAG = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PRIO = 8'h20;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int IPL_LO = 5;
  localparam int IPL_HI = 7;
  localparam int CORE_MSB_BIT = 3;
  localparam int CORE_RSVD_BIT = 2;
  localparam int NEST_BIT = 15;
  localparam int TRAP_LO = 1;
  localparam int TRAP_HI = 4;
  localparam int ALT_BIT = 15;
  localparam int DISABLE_INSTR_ACTIVE_BIT = 14;
  localparam int EDGE_LO = 0;
  localparam int EDGE_HI = 4;
  localparam int TRACE_LVL_LO = 8;
  localparam int TRACE_LVL_HI = 11;
  localparam int PRIO_STRIDE = 4;

  // ---------------------------------------------------------------------
  // Implemented source positions, one word per flag bank
  // ---------------------------------------------------------------------
  localparam logic [SRC_COUNT-1:0] IMPL_MASK = {
    16'h3FFE, 16'h210E, 16'h4066, 16'h3FE3, 16'hFEDF, 16'h3FEF
  };
  localparam int EXT_VEC [EXT_COUNT] = '{0, 20, 29, 53, 54};
  localparam logic [PRIO_W-1:0] PRIO_MAX = 3'h7;

  // ---------------------------------------------------------------------
  // Vector tables
  // ---------------------------------------------------------------------
  localparam logic [DATA_W-1:0] IVT_BASE = 16'h0014;
  localparam logic [DATA_W-1:0] ALT_VECTOR_TABLE_BASE = 16'h0114;

  // ---------------------------------------------------------------------
  // State of the controller
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [SRC_COUNT-1:0] flags;
    logic [SRC_COUNT-1:0] enables;
    logic [SRC_COUNT-1:0][PRIO_W-1:0] prio;
    logic [PRIO_W-1:0] ipl_low;
    logic cpu_prio_msb;
    logic nesting_off;
    logic [TRAP_COUNT-1:0] trap;
    logic alt_table_select;
    logic [EXT_COUNT-1:0] edge_sel;
    logic [EXT_COUNT-1:0] ext_prev;
    logic [VEC_W-1:0] latched_vector_index;
    logic [LEVEL_W-1:0] latched_prio_level;
    logic req;
    logic [DATA_W-1:0] vec_addr;
    logic [DATA_W-1:0] rdata;
  } pirc_state_s;

  typedef struct packed {
    logic hit;
    logic [VEC_W-1:0] vec;
    logic [LEVEL_W-1:0] lvl;
  } pirc_win_s;

endpackage

//--- logic/pirc_arbiter.sv
// Priority arbiter: picks the highest pending level above the CPU level.
`timescale 1ns/1ps
module pirc_arbiter
  import pirc_pkg::*;
#(
  parameter int N_SRC = SRC_COUNT
) (
  input wire logic [N_SRC-1:0] pend_i, // Flag and enable both set
  input wire logic [N_SRC-1:0][PRIO_W-1:0] prio_i, // Per-source level
  input wire logic [LEVEL_W-1:0] cpu_level_i, // Current CPU level
  output pirc_win_s win_o // Winning source
);

  generate
    if (N_SRC > (1 << VEC_W)) begin : g_bad
      $error("pirc_arbiter: too many sources for the vector width");
    end
  endgenerate

  // Scanning upward with a strict compare keeps the lower vector on ties.
  always_comb begin
    logic [LEVEL_W-1:0] best;
    best = cpu_level_i;
    win_o = '0;
    for (int i = 0; i < N_SRC; i++) begin
      if (pend_i[i] && ({1'b0, prio_i[i]} > best)) begin
        best = {1'b0, prio_i[i]};
        win_o.hit = 1'b1;
        win_o.vec = VEC_W'(i);
        win_o.lvl = best;
      end
    end
  end

endmodule

//--- sim/pirc_props.sv
// Checker: concurrent properties on the interrupt controller ports.
`timescale 1ns/1ps
module pirc_props
  import pirc_pkg::*;
(
  input wire logic mclk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic [ADDR_W-1:0] reg_addr_i, // Address
  input wire logic [DATA_W-1:0] reg_wdata_i, // Write data
  input wire logic reg_we_i, // Write strobe
  input wire logic reg_re_i, // Read strobe
  input wire logic [DATA_W-1:0] reg_rdata_o, // Read data
  input wire logic irq_ack_i, // CPU takes interrupt
  input wire logic cpu_level_load_i, // CPU level load
  input wire logic irq_req_o, // Request
  input wire logic [VEC_W-1:0] irq_vector_o, // Latched vector
  input wire logic [LEVEL_W-1:0] irq_level_o, // Latched level
  input wire logic [DATA_W-1:0] vec_addr_o, // Fetch address
  input wire logic [LEVEL_W-1:0] cpu_prio_level_o, // CPU level
  input wire logic nesting_off_o // Nesting disabled
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  logic st_wr;
  // Ack and level load also move the level, so they are kept apart.
  assign st_wr = reg_we_i && reg_addr_i == OFF_STATUS && !irq_ack_i
    && !cpu_level_load_i;
  property p_core_rsvd;
    reg_re_i && reg_addr_i == OFF_CORE |=>
      reg_rdata_o[CORE_RSVD_BIT] && reg_rdata_o[15:4] == 12'h000;
  endproperty
  a_core_rsvd: assert property (p_core_rsvd)
    else $error("core control reserved bit wrong");
  property p_req_level;
    irq_req_o |-> irq_level_o != 4'h0 && !irq_level_o[3];
  endproperty
  a_req_level: assert property (p_req_level)
    else $error("request with a bad level");
  sequence s_masked;
    (cpu_prio_level_o[3] || &cpu_prio_level_o[2:0]) [*2];
  endsequence
  property p_masked;
    s_masked |-> !irq_req_o;
  endproperty
  a_masked: assert property (p_masked)
    else $error("request while user interrupts masked");
  property p_vec_addr;
    irq_req_o |-> vec_addr_o == IVT_BASE + {8'h00, irq_vector_o, 1'b0}
      || vec_addr_o == ALT_VECTOR_TABLE_BASE + {8'h00, irq_vector_o, 1'b0};
  endproperty
  a_vec_addr: assert property (p_vec_addr)
    else $error("fetch address not in a table");
  property p_nest_wr;
    reg_we_i && reg_addr_i == OFF_GCTL_A |=>
      nesting_off_o == $past(reg_wdata_i[NEST_BIT]);
  endproperty
  a_nest_wr: assert property (p_nest_wr)
    else $error("nesting bit did not follow write");
  property p_nest_lock;
    nesting_off_o && st_wr |=> $stable(cpu_prio_level_o);
  endproperty
  a_nest_lock: assert property (p_nest_lock)
    else $error("level changed while nesting off");
  property p_ipl_wr;
    !nesting_off_o && st_wr |=>
      cpu_prio_level_o[2:0] == $past(reg_wdata_i[IPL_HI:IPL_LO])
      && $stable(cpu_prio_level_o[3]);
  endproperty
  a_ipl_wr: assert property (p_ipl_wr)
    else $error("status write did not set level");
  property p_ack_lvl;
    irq_ack_i && !reg_we_i && !cpu_level_load_i |=>
      cpu_prio_level_o[2:0] ==
      ($past(nesting_off_o) ? 3'h7 : $past(irq_level_o[2:0]));
  endproperty
  a_ack_lvl: assert property (p_ack_lvl)
    else $error("ack did not load latched level");
  property p_trace_hold;
    !irq_req_o |-> $stable(irq_vector_o) && $stable(irq_level_o);
  endproperty
  a_trace_hold: assert property (p_trace_hold)
    else $error("trace changed with no request");
  c_req: cover property ($rose(irq_req_o));
  c_ack: cover property (irq_ack_i);
  c_alt: cover property (irq_req_o && vec_addr_o[8]);
endmodule

bind pirc_top pirc_props i_props (.mclk_i, .sys_rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .irq_ack_i,
  .cpu_level_load_i, .irq_req_o, .irq_vector_o, .irq_level_o,
  .vec_addr_o, .cpu_prio_level_o, .nesting_off_o);

//--- sim/pirc_cpu_model.sv
// Behavioural CPU core that takes offered interrupts after a set delay.
`timescale 1ns/1ps
module pirc_cpu_model (
  input wire logic mclk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic en_i, // Take interrupts
  input wire logic [3:0] delay_i, // Cycles before ack
  input wire logic irq_req_i, // Request from controller
  output logic irq_ack_o // Ack pulse
);
  logic [3:0] cnt;
  logic [1:0] hold;
  // The new level needs two edges to lower the request, so the model
  // rests after each ack rather than taking a stale request twice.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt <= 4'h0;
      hold <= 2'h0;
      irq_ack_o <= 1'b0;
    end else if (irq_ack_o) begin
      irq_ack_o <= 1'b0;
      hold <= 2'h3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (en_i && irq_req_i) begin
      irq_ack_o <= cnt == delay_i;
      cnt <= (cnt == delay_i) ? 4'h0 : cnt + 4'h1;
    end else begin
      cnt <= 4'h0;
    end
  end
endmodule

//--- sim/prioritized_interrupt_controller_tb.sv
// Self-checking bench for the prioritized interrupt controller.
`timescale 1ns/1ps
module prioritized_interrupt_controller_tb;
  import pirc_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [SRC_COUNT-1:0] ev = '0;
  logic [EXT_COUNT-1:0] ext = '0;
  logic [TRAP_COUNT-1:0] trap = '0;
  logic disable_instr_active = 1'b0;
  logic lvl_ld = 1'b0;
  logic [LEVEL_W-1:0] lvl = '0;
  logic cpu_en = 1'b0;
  logic ack, req, nest;
  logic [DATA_W-1:0] rdata, vaddr, irq_st;
  logic [VEC_W-1:0] vec;
  logic [LEVEL_W-1:0] ilvl, cpul;
  int n_errors = 0;
  int tests_run = 0;
  assign irq_st = {req, 3'h0, ilvl, 1'b0, vec};
  initial forever #12.5 mclk_i = ~mclk_i;
  pirc_top #(.N_SRC(SRC_COUNT)) i_dut (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .src_event_i(ev),
    .ext_irq_i(ext), .trap_event_i(trap), .disable_instr_active_active_i(disable_instr_active),
    .irq_ack_i(ack), .cpu_level_load_i(lvl_ld), .cpu_level_i(lvl),
    .irq_req_o(req), .irq_vector_o(vec), .irq_level_o(ilvl),
    .vec_addr_o(vaddr), .cpu_prio_level_o(cpul), .nesting_off_o(nest));
  pirc_cpu_model i_cpu (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .en_i(cpu_en), .delay_i(4'h3), .irq_req_i(req), .irq_ack_o(ack));
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, exp, input string s);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk_i);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge mclk_i);
    re <= 1'b1;
    addr <= a;
    @(posedge mclk_i);
    re <= 1'b0;
    #1;
    chk(rdata, e, "read data");
  endtask
  task automatic fire(input logic [SRC_COUNT-1:0] m);
    @(posedge mclk_i);
    ev <= m;
    @(posedge mclk_i);
    ev <= '0;
  endtask
  task automatic load(input logic [LEVEL_W-1:0] v);
    @(posedge mclk_i);
    lvl_ld <= 1'b1;
    lvl <= v;
    @(posedge mclk_i);
    lvl_ld <= 1'b0;
    tick(1);
  endtask
  task automatic pin(input int i, input logic v);
    logic [EXT_COUNT-1:0] m;
    m = EXT_COUNT'(1 << i);
    @(posedge mclk_i);
    ext <= v ? (ext | m) : (ext & ~m);
    tick(3);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(OFF_STATUS, 16'h0000);
    rd(OFF_CORE, 16'h0004);
    rd(OFF_GCTL_A, 16'h0000);
    rd(OFF_GCTL_B, 16'h0000);
    rd(8'h05, 16'h0000);
    wr(OFF_PRIO + 8'h0e, 16'hffff);
    rd(OFF_PRIO + 8'h0e, 16'h0000);
    rd(OFF_PRIO + 8'h11, 16'h0000);
    wr(OFF_PRIO, 16'hffff);
    rd(OFF_PRIO, 16'h7777);
  endtask
  task automatic t_flags();
    wr(OFF_FLAG, 16'hffff);
    rd(OFF_FLAG, 16'h3fef);
    wr(OFF_FLAG, 16'h0000);
    fire(96'h2010);
    tick(1);
    rd(OFF_FLAG, 16'h2000);
    wr(OFF_FLAG, 16'h0000);
    rd(OFF_FLAG, 16'h0000);
  endtask
  task automatic t_req();
    wr(OFF_PRIO, 16'h0550);
    wr(OFF_ENABLE, 16'h0006);
    fire(96'h6);
    tick(2);
    chk(irq_st, 16'h8501, "winner");
    chk(vaddr, 16'h0016, "fetch address");
    rd(OFF_TRACE, 16'h0501);
    wr(OFF_ENABLE, 16'h0004);
    tick(2);
    chk(irq_st, 16'h8502, "winner");
    wr(OFF_GCTL_B, 16'h8000);
    tick(2);
    chk(vaddr, 16'h0118, "fetch address");
    wr(OFF_STATUS, 16'h00a0);
    tick(2);
    chk(irq_st, 16'h0502, "equal level");
    wr(OFF_STATUS, 16'h0080);
    tick(2);
    chk(irq_st, 16'h8502, "lower level");
    wr(OFF_PRIO, 16'h0750);
    wr(OFF_STATUS, 16'h00e0);
    tick(2);
    chk(irq_st, 16'h0702, "level seven");
    rd(OFF_STATUS, 16'h00e0);
    wr(OFF_FLAG, 16'h0000);
    wr(OFF_GCTL_B, 16'h0000);
    wr(OFF_STATUS, 16'h0000);
  endtask
  task automatic t_nest();
    wr(OFF_GCTL_A, 16'h8000);
    tick(1);
    chk({15'h0000, nest}, 16'h0001, "nesting");
    wr(OFF_STATUS, 16'h0060);
    rd(OFF_STATUS, 16'h0000);
    for (int i = 0; i < TRAP_COUNT; i++) begin
      @(posedge mclk_i);
      trap <= 4'(1 << i);
      @(posedge mclk_i);
      trap <= '0;
      rd(OFF_GCTL_A, 16'h8000 | 16'(2 << i));
      wr(OFF_GCTL_A, 16'h8000);
    end
    wr(OFF_GCTL_A, 16'hffff);
    rd(OFF_GCTL_A, 16'h801e);
    wr(OFF_GCTL_A, 16'h0000);
    wr(OFF_GCTL_B, 16'h8000);
    disable_instr_active <= 1'b1;
    rd(OFF_GCTL_B, 16'hc000);
    disable_instr_active <= 1'b0;
    wr(OFF_GCTL_B, 16'h0000);
  endtask
  task automatic t_ack();
    wr(OFF_PRIO, 16'h4000);
    wr(OFF_ENABLE, 16'h0008);
    cpu_en <= 1'b1;
    fire(96'h8);
    tick(10);
    cpu_en <= 1'b0;
    chk({12'h000, cpul}, 16'h0004, "level after ack");
    chk(irq_st, 16'h0403, "trace after ack");
    load(4'h8);
    chk({12'h000, cpul}, 16'h0008, "trap level");
    // Level six would win at CPU level zero, so only the top bit masks it.
    wr(OFF_PRIO, 16'h6000);
    rd(OFF_CORE, 16'h000c);
    wr(OFF_CORE, 16'h0000);
    rd(OFF_CORE, 16'h000c);
    rd(OFF_STATUS, 16'h0000);
    chk(irq_st, 16'h0403, "masked at trap level");
    load(4'h0);
    wr(OFF_GCTL_A, 16'h8000);
    cpu_en <= 1'b1;
    tick(10);
    cpu_en <= 1'b0;
    chk({12'h000, cpul}, 16'h0007, "ack with nesting off");
    wr(OFF_GCTL_A, 16'h0000);
    wr(OFF_FLAG, 16'h0000);
    wr(OFF_ENABLE, 16'h0000);
  endtask
  task automatic t_ext();
    logic [ADDR_W-1:0] fa;
    logic [DATA_W-1:0] fb;
    for (int i = 0; i < EXT_COUNT; i++) begin
      fa = OFF_FLAG + 8'(EXT_VEC[i] / 16);
      fb = 16'(1 << (EXT_VEC[i] % 16));
      wr(OFF_GCTL_B, 16'(1 << i));
      pin(i, 1'b1);
      rd(fa, 16'h0000);
      pin(i, 1'b0);
      rd(fa, fb);
      wr(fa, 16'h0000);
      wr(OFF_GCTL_B, 16'h0000);
      pin(i, 1'b1);
      rd(fa, fb);
      wr(fa, 16'h0000);
      pin(i, 1'b0);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_flags();
    t_req();
    t_nest();
    t_ack();
    t_ext();
    give_verdict();
  end
endmodule
